// ===== sim/lspc_link_partner.sv
// far-side clock request drivers and pull-ups
`timescale 1ns/1ps

module lspc_link_partner (
  // far-side requests, high pulls the wire low
  input  wire logic [3:0] ep_req,
  // device side of the open-drain pins
  input  wire logic [3:0] dev_n,
  input  wire logic [3:0] dev_oe,
  // resolved wire level
  output logic      [3:0] clkreq_n
);
  // wired-and with pull-up: undriven reads high
  assign clkreq_n = ~(ep_req | (dev_oe & ~dev_n));
endmodule

// ===== sim/lspc_power_ctrl_test.sv
// self-checking bench for the link substate power control
`timescale 1ns/1ps

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end

module lspc_power_ctrl_test
  import lspc_pkg::*;
;
  // ==========================================================================
  // signals
  logic                 clk = 0, sys_rst = 1, dstate_valid = 0, clkbuf_pd = 0;
  lspc_dstate_t         dstate_req = LSPC_D0, dstate, e_ds;
  lspc_lstate_t [3:0]   ls_in = '0, link_state, e_ls;
  lspc_port_cfg_t [3:0] cfg = '0;
  logic [3:0]           ep_req = 0, clk_needed = 0, clkreq_n, out_n, oe, in_l11, rx_off, pll_req, t;
  logic [3:0]           e_l11, e_oe, e_on;
  logic [3:1]           refclk_en, e_ref;
  logic                 pll_pd, core_clk_run, e_pd;
  int                   n_errors = 0, compares = 0, seed;

  initial forever #2.5 clk = ~clk;

  lspc_power_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .dstate_req(dstate_req), .dstate_valid(dstate_valid),
    .dstate(dstate), .link_state_in(ls_in), .port_cfg(cfg), .link_state(link_state), .clkreq_in_n(clkreq_n),
    .clkreq_out_n(out_n), .clkreq_oe(oe), .clk_needed(clk_needed), .clkbuf_pd(clkbuf_pd),
    .refclk_en(refclk_en), .in_l11(in_l11), .rx_buf_off(rx_off), .pll_off_req(pll_req), .pll_pd(pll_pd),
    .core_clk_run(core_clk_run));
  lspc_link_partner u_far (.ep_req(ep_req), .dev_n(out_n), .dev_oe(oe), .clkreq_n(clkreq_n));

  // ==========================================================================
  // reference model, stateless per edge apart from the held e_ds, so no drift after reset
  function automatic logic exp_l11(lspc_port_cfg_t c, lspc_lstate_t l, logic req_n);
    return c.present & c.partner_l11 & c.l11_en & (l == LSPC_L1) & ~req_n;
  endfunction

  always_comb begin
    for (int p = 0; p < 4; p++) begin
      t[p] = exp_l11(cfg[p], ls_in[p], clkreq_n[p]);
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      e_ds <= LSPC_D0; e_ls <= '0; e_l11 <= 0; e_pd <= 0; e_oe <= 0; e_on <= 4'hF; e_ref <= 0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        e_ls[p] <= (ls_in[p] == LSPC_L0S && !cfg[p].aspm_en) ? LSPC_L0 : ls_in[p];
      end
      if (dstate_valid) e_ds <= dstate_req;
      e_l11 <= t; e_pd <= &t; e_on <= 4'h0;
      e_oe <= {clk_needed[3:1], ~&clkreq_n[3:1] | clk_needed[0]};
      e_ref <= clkbuf_pd ? 3'h0 : ~clkreq_n[3:1];
    end
  end

  always @(negedge clk) begin
    `CHK(dstate, e_ds)
    `CHK(link_state, e_ls)
    `CHK(in_l11, e_l11)
    `CHK({rx_off, pll_req}, {e_l11, e_l11})
    `CHK({pll_pd, core_clk_run}, {e_pd, ~e_pd})
    `CHK({oe, out_n}, {e_oe, e_on})
    `CHK(refclk_en, e_ref)
  end

  // ==========================================================================
  // stimulus
  task automatic rnd();
    for (int p = 0; p < 4; p++) begin
      ls_in[p] <= ($urandom_range(7, 0) != 0) ? LSPC_L1 : lspc_lstate_t'($urandom_range(4, 0));
      cfg[p] <= ($urandom_range(7, 0) != 0) ? lspc_port_cfg_t'(4'hF) : lspc_port_cfg_t'(4'($urandom_range(15, 0)));
      ep_req[p] <= $urandom_range(7, 0) != 0;
    end
    clk_needed <= 4'($urandom) & 4'($urandom);
    dstate_valid <= $urandom_range(3, 0) == 0;
    dstate_req <= lspc_dstate_t'($urandom_range(4, 0));
    clkbuf_pd <= $urandom_range(7, 0) == 0;
  endtask

  task automatic test_done();
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    seed = $urandom(32'h3d918cf0);
    repeat (4) @(posedge clk);
    sys_rst <= 0;
    // all ports capable, in L1, requests held: shared PLL goes off
    cfg <= {4{lspc_port_cfg_t'(4'hF)}}; ls_in <= {4{LSPC_L1}}; ep_req <= 4'hF;
    repeat (5) @(posedge clk);
    ep_req <= 4'hB; // exit then back-to-back re-entry
    @(posedge clk) ep_req <= 4'hF;
    @(posedge clk) cfg[3].present <= 0; // empty port keeps PLL on
    @(posedge clk) begin cfg[3].present <= 1; ls_in[1] <= LSPC_L0S; end // entry refused outside L1
    @(posedge clk) clkbuf_pd <= 1;
    @(posedge clk) clkbuf_pd <= 0;
    repeat (2000) @(posedge clk) rnd();
    // quiet inputs so the release edge samples nothing the flops never saw
    @(posedge clk) begin
      sys_rst <= 1;
      dstate_valid <= 0;
      ls_in <= '0;
      cfg <= '0;
      ep_req <= 0;
      clk_needed <= 0;
    end
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    repeat (1000) @(posedge clk) rnd();
    test_done();
  end
endmodule

// ===== verilog/lspc_pkg.sv
// package of shared types and constants for the link substate power control
package lspc_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned LSPC_NUM_PORTS = 4;
  localparam int unsigned LSPC_UP_PORT   = 0;

  // ==========================================================================
  // power state encodings
  typedef enum logic [2:0] {
    LSPC_D0,
    LSPC_D1,
    LSPC_D2,
    LSPC_D3_HOT,
    LSPC_D3_COLD
  } lspc_dstate_t;

  typedef enum logic [2:0] {
    LSPC_L0,
    LSPC_L0S,
    LSPC_L1,
    LSPC_L23_READY,
    LSPC_L3
  } lspc_lstate_t;

  // ==========================================================================
  // per-port configuration carrier
  typedef struct packed {
    logic present;      // slot occupied
    logic partner_l11;  // link partner can do the substate
    logic l11_en;       // substate enabled by configuration
    logic aspm_en;      // active-state transitions allowed
  } lspc_port_cfg_t;

  // ==========================================================================
  // reset values
  localparam lspc_dstate_t LSPC_DSTATE_RST = LSPC_D0;
  localparam lspc_lstate_t LSPC_LSTATE_RST = LSPC_L0;
  localparam logic         LSPC_PIN_HIGH   = 1'h1;
  localparam logic         LSPC_PIN_LOW    = 1'h0;

endpackage

// ===== verilog/lspc_port_tracker.sv
// per-port substate tracker for one switch port
`timescale 1ns/1ps

module lspc_port_tracker
  import lspc_pkg::*;
(
  // clock and reset
  input  wire logic           clk,
  input  wire logic           sys_rst,
  // port state
  input  wire lspc_lstate_t   link_state,
  input  wire logic           clkreq_asserted,
  input  wire lspc_port_cfg_t cfg,
  // substate
  output logic                in_l11_next,
  output logic                in_l11
);

  // ==========================================================================
  // substate machine
  typedef enum logic {LSPC_SUB_L1_0, LSPC_SUB_L1_1} lspc_sub_t;

  lspc_sub_t state_reg;
  lspc_sub_t state_next;
  logic      capable;

  always_comb begin
    // an empty slot or a partner without support never counts as in the substate
    capable    = cfg.present && cfg.partner_l11 && cfg.l11_en;  // RULE_08
    state_next = state_reg;
    unique case (state_reg)
      LSPC_SUB_L1_0: begin
        if (capable && link_state == LSPC_L1 && clkreq_asserted) begin
          state_next = LSPC_SUB_L1_1;  // RULE_04
        end
      end
      LSPC_SUB_L1_1: begin
        // leaving L1 or losing capability also drops back, so no stale power-down
        if (!clkreq_asserted || !capable || link_state != LSPC_L1) begin
          state_next = LSPC_SUB_L1_0;  // RULE_06
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= LSPC_SUB_L1_0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign in_l11_next = (state_next == LSPC_SUB_L1_1);
  assign in_l11      = (state_reg == LSPC_SUB_L1_1);

endmodule

// ===== verilog/lspc_power_ctrl.sv
// top of the link substate power control for a four-port switch
`timescale 1ns/1ps

// Behaviour
// RULE_01: track device power states D0 to D3-cold
// RULE_02: track link states per port, allow ASPM
// RULE_03: one substate tracker per switch port
// RULE_04: enter L1.1 only from L1 with clkreq
// RULE_05: in L1.1 receiver off, PLL off requested
// RULE_06: clkreq released returns port to L1
// RULE_07: shared PLL off only when all in L1.1
// RULE_08: empty or incapable port never in L1.1
// RULE_09: software keeps incapable ports in plain L1
// RULE_10: downstream clkreqs combined onto upstream clkreq
// RULE_11: released clkreq stops that downstream refclk
// RULE_12: PLL power-down is AND, drops same cycle
module lspc_power_ctrl
  import lspc_pkg::*;
#(
  parameter int unsigned NP = LSPC_NUM_PORTS
)(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // device power state
  input  wire lspc_dstate_t             dstate_req,
  input  wire logic                     dstate_valid,
  output lspc_dstate_t                  dstate,
  // link state from each port's physical layer
  input  wire lspc_lstate_t [NP-1:0]    link_state_in,
  input  wire lspc_port_cfg_t [NP-1:0]  port_cfg,
  output lspc_lstate_t [NP-1:0]         link_state,
  // clock request pins, active low, open drain
  input  wire logic [NP-1:0]            clkreq_in_n,
  output logic [NP-1:0]                 clkreq_out_n,
  output logic [NP-1:0]                 clkreq_oe,
  input  wire logic [NP-1:0]            clk_needed,
  // reference clock buffers
  input  wire logic                     clkbuf_pd,
  output logic [NP-1:1]                 refclk_en,
  // power-down controls
  output logic [NP-1:0]                 in_l11,
  output logic [NP-1:0]                 rx_buf_off,
  output logic [NP-1:0]                 pll_off_req,
  output logic                          pll_pd,
  output logic                          core_clk_run
);

  // ==========================================================================
  // registers
  lspc_dstate_t              dstate_reg,       dstate_next;
  lspc_lstate_t [NP-1:0]     link_state_reg,   link_state_next;
  logic [NP-1:0]             clkreq_oe_reg,    clkreq_oe_next;
  logic [NP-1:0]             clkreq_out_reg,   clkreq_out_next;
  logic [NP-1:1]             refclk_en_reg,    refclk_en_next;
  logic [NP-1:0]             rx_buf_off_reg,   rx_buf_off_next;
  logic [NP-1:0]             pll_off_req_reg,  pll_off_req_next;
  logic                      pll_pd_reg,       pll_pd_next;
  logic                      core_clk_run_reg, core_clk_run_next;
  logic [NP-1:0]             sub_next;
  logic [NP-1:0]             sub_now;
  logic                      dn_clk_wanted;

  // ==========================================================================
  // per-port trackers
  for (genvar p = 0; p < NP; p++) begin : g_port
    lspc_port_tracker u_trk (  // RULE_03
      .clk             (clk),
      .sys_rst         (sys_rst),
      .link_state      (link_state_in[p]),
      .clkreq_asserted (clkreq_in_n[p] == LSPC_PIN_LOW),
      .cfg             (port_cfg[p]),
      .in_l11_next     (sub_next[p]),
      .in_l11          (sub_now[p])
    );
  end

  // ==========================================================================
  // next-state logic
  always_comb begin
    dstate_next = dstate_reg;
    if (dstate_valid) begin
      dstate_next = dstate_req;  // RULE_01
    end
    for (int p = 0; p < NP; p++) begin
      link_state_next[p] = link_state_in[p];  // RULE_02
      // without active-state enable, L0s is not a legal resting state
      if (link_state_in[p] == LSPC_L0S && !port_cfg[p].aspm_en) begin
        link_state_next[p] = LSPC_L0;  // RULE_02
      end
    end
    rx_buf_off_next  = sub_next;  // RULE_05
    pll_off_req_next = sub_next;  // RULE_05
    // built from next values so the power-down falls with the port's exit
    pll_pd_next      = &sub_next;  // RULE_07 RULE_12
    // core clock flag kept as its own flop so the pin has no gate in front
    core_clk_run_next = !pll_pd_next;  // RULE_07
    dn_clk_wanted    = 1'h0;
    for (int p = 1; p < NP; p++) begin
      if (clkreq_in_n[p] == LSPC_PIN_LOW) begin
        dn_clk_wanted = 1'h1;  // RULE_10
      end
      refclk_en_next[p] = !clkbuf_pd && (clkreq_in_n[p] == LSPC_PIN_LOW);  // RULE_11
    end
    clkreq_out_next = {NP{LSPC_PIN_LOW}};
    clkreq_oe_next  = clk_needed;
    clkreq_oe_next[LSPC_UP_PORT] = dn_clk_wanted || clk_needed[LSPC_UP_PORT];  // RULE_10
  end

  // ==========================================================================
  // state registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dstate_reg      <= LSPC_DSTATE_RST;
      link_state_reg  <= {NP{LSPC_LSTATE_RST}};
      clkreq_oe_reg   <= '0;
      clkreq_out_reg  <= {NP{LSPC_PIN_HIGH}};
      refclk_en_reg   <= '0;
      rx_buf_off_reg  <= '0;
      pll_off_req_reg <= '0;
      pll_pd_reg      <= 1'h0;
      core_clk_run_reg <= 1'h1;
    end else begin
      dstate_reg      <= dstate_next;
      link_state_reg  <= link_state_next;
      clkreq_oe_reg   <= clkreq_oe_next;
      clkreq_out_reg  <= clkreq_out_next;
      refclk_en_reg   <= refclk_en_next;
      rx_buf_off_reg  <= rx_buf_off_next;
      pll_off_req_reg <= pll_off_req_next;
      pll_pd_reg      <= pll_pd_next;
      core_clk_run_reg <= core_clk_run_next;
    end
  end

  // ==========================================================================
  // outputs
  assign dstate       = dstate_reg;
  assign link_state   = link_state_reg;
  assign clkreq_oe    = clkreq_oe_reg;
  assign clkreq_out_n = clkreq_out_reg;
  assign refclk_en    = refclk_en_reg;
  assign in_l11       = sub_now;
  assign rx_buf_off   = rx_buf_off_reg;
  assign pll_off_req  = pll_off_req_reg;
  assign pll_pd       = pll_pd_reg;
  assign core_clk_run = core_clk_run_reg;  // RULE_07

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_dstate_follows_req: assert property (  // RULE_01
    dstate_valid |=> dstate == $past(dstate_req))
    else $error("device power state not taken");

  a_dstate_holds: assert property (  // RULE_01
    !dstate_valid |=> $stable(dstate))
    else $error("device power state moved without request");

  a_pll_needs_all: assert property (  // RULE_07
    pll_pd |-> (&in_l11) && !core_clk_run)
    else $error("pll down while a port is out of the substate");

  a_pll_drop_same: assert property (  // RULE_12
    pll_pd == (&in_l11))
    else $error("pll power-down not tied to all ports");

  a_core_clk_inv: assert property (  // RULE_07
    core_clk_run == !pll_pd)
    else $error("core clock run not inverse of pll down");

  a_refclk_gated: assert property (  // RULE_11
    clkbuf_pd |=> refclk_en == '0)
    else $error("reference clock runs while buffers off");

  a_upstream_combine: assert property (  // RULE_10
    (clkreq_in_n[NP-1:1] != '1) |=> clkreq_oe[LSPC_UP_PORT] && !clkreq_out_n[LSPC_UP_PORT])
    else $error("downstream request not passed upstream");

  for (genvar p = 0; p < NP; p++) begin : g_chk
    a_entry_from_l1: assert property (  // RULE_04
      $rose(in_l11[p]) |-> $past(link_state_in[p] == LSPC_L1 && clkreq_in_n[p] == LSPC_PIN_LOW))
      else $error("substate entered from wrong state");

    a_rx_off_in_l11: assert property (  // RULE_05
      in_l11[p] |-> rx_buf_off[p] && pll_off_req[p])
      else $error("receiver left on in substate");

    a_rx_on_outside: assert property (  // RULE_06
      !in_l11[p] |-> !rx_buf_off[p] && !pll_off_req[p])
      else $error("receiver kept off outside substate");

    a_entry_needs_l1: assert property (  // RULE_04
      link_state_in[p] != LSPC_L1 |=> !in_l11[p])
      else $error("substate held outside L1");

    a_pll_up_exit: assert property (  // RULE_12
      $fell(in_l11[p]) |-> !pll_pd && core_clk_run)
      else $error("pll still down after a port left");

    a_exit_on_release: assert property (  // RULE_06
      in_l11[p] && clkreq_in_n[p] |=> !in_l11[p] && !rx_buf_off[p] && !pll_pd)
      else $error("no return to L1 after release");

    a_incapable_out: assert property (  // RULE_08
      !port_cfg[p].present || !port_cfg[p].partner_l11 |=> !in_l11[p] && !pll_pd)
      else $error("incapable port counted in substate");

    a_link_tracked: assert property (  // RULE_02
      $past(port_cfg[p].aspm_en) || $past(link_state_in[p]) != LSPC_L0S |-> link_state[p] == $past(link_state_in[p]))
      else $error("link state not tracked");
  end

  for (genvar p = 1; p < NP; p++) begin : g_ref
    a_refclk_stop: assert property (  // RULE_11
      clkreq_in_n[p] |=> !refclk_en[p])
      else $error("reference clock runs after release");
  end

  c_port_enters: cover property ($rose(in_l11[1]));
  c_pll_down:    cover property ($rose(pll_pd));
  c_pll_back:    cover property (pll_pd ##1 !pll_pd);
  c_up_request:  cover property (clkreq_oe[LSPC_UP_PORT] && in_l11[LSPC_UP_PORT] == 1'h0);
  c_entry_refused: cover property (link_state_in[1] != LSPC_L1 && clkreq_in_n[1] == LSPC_PIN_LOW ##1 !in_l11[1]);

endmodule
